/* File: serial_ctrl_pkg.sv */
// package: register map, field positions and transport structs for the serial control block
package serial_ctrl_pkg;
  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_TXRX_CONTROL_TWO  = 8'h00;
  localparam logic [7:0] ADDR_SINGLE_WIRE_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_GLOBAL_CTRL       = 8'h08;
  localparam logic [7:0] ADDR_STATUS            = 8'h0C;
  localparam logic [7:0] ADDR_TX_DATA           = 8'h10;
  localparam logic [7:0] ADDR_RX_DATA           = 8'h14;
  localparam logic [7:0] ADDR_CLOCK_CTRL        = 8'h18;
  // reset values
  localparam logic [7:0] TXRX_CONTROL_TWO_RST   = 8'h00;
  localparam logic [7:0] SINGLE_WIRE_CTRL_RST   = 8'h00;
  // txrx_control_two field positions
  localparam int BIT_TRANSMITTER_ON   = 7;
  localparam int BIT_RECEIVER_ON      = 6;
  localparam int BIT_RX_STOP_COUNT    = 5;
  localparam int BIT_ADDRESS_DETECT   = 4;
  localparam int BIT_PIN_WAKEUP       = 3;
  localparam int BIT_RX_IRQ           = 2;
  localparam int BIT_TX_IDLE_IRQ      = 1;
  localparam int BIT_TX_EMPTY_IRQ     = 0;
  // global control field positions
  localparam int BIT_GLOBAL_ON        = 1;
  localparam int BIT_CHAR_LENGTH      = 0;
  // status field positions
  localparam int BIT_OVERRUN          = 0;
  localparam int BIT_RX_AVAIL         = 1;
  localparam int BIT_TX_IDLE          = 2;
  localparam int BIT_TX_EMPTY         = 3;
  localparam int BIT_ADDR_SEEN        = 4;
  localparam int BIT_WAKE_SEEN        = 5;
  localparam int BIT_IRQ              = 6;
  localparam int BIT_RX_NINTH         = 7;
  // link constants
  localparam int TX_STOP_BITS         = 2;
  localparam logic [1:0] AXI_OKAY     = 2'b00;
  localparam logic [1:0] AXI_SLVERR   = 2'b10;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  // one pin's drive as two signals
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;
endpackage

/* File: serial_ctrl.sv */
// serial transceiver control: enables, stop count, address detect, wake-up, irq and single-wire pin sharing
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

// Functional notes
// R1: transmitter off aborts, resets, floats transmit pin
// R2: transmit only with transmitter and global on
// R3: clearing transmitter mid-character aborts at once
// R4: receiver off aborts, resets, floats shared pin; code drives it for single-wire transmit when the transmitter is on
// R5: receive only with receiver and global on
// R6: clearing receiver mid-character aborts reception
// R7: receiver stop bits: one or two by select
// R8: transmitter always sends two stop bits
// R9: address bit set marks address, raises irq
// R10: address bit clear: word discarded, no irq
// R11: clock off, wake on: falling edge requests
// R12: clock running: never a pin wake request
// R13: wake-up off: falling edge does nothing
// R14: rx irq on: overrun or available sets request
// R15: tx idle irq on: idle flag sets request
// R16: tx empty irq on: empty flag sets request
// R17: single-wire off: shared pin receives only
// R18: single-wire on: shared pin receives or transmits
// R19: single-wire, both on: shared pin only receives
// R20: upper seven single-wire bits read zero
// R21: char length selects eight or nine bits
// R22: global off clears enables and flags; code clears only overrun, available and address flags, not the wake flag
// R23: request is OR of enabled sources; code also ORs in the wake flag, which no irq enable gates
module serial_ctrl
  import serial_ctrl_pkg::*;
#(
  parameter int BAUD_DIV = 16
) (
  // clock and reset
  input  wire  logic        SYS_CLK,
  input  wire  logic        RSTN,
  // axi4-lite write channels
  input  wire  logic [7:0]  S_AXI_AWADDR,
  input  wire  logic        S_AXI_AWVALID,
  output logic              S_AXI_AWREADY,
  input  wire  logic [31:0] S_AXI_WDATA,
  input  wire  logic [3:0]  S_AXI_WSTRB,
  input  wire  logic        S_AXI_WVALID,
  output logic              S_AXI_WREADY,
  output logic [1:0]        S_AXI_BRESP,
  output logic              S_AXI_BVALID,
  input  wire  logic        S_AXI_BREADY,
  // axi4-lite read channels
  input  wire  logic [7:0]  S_AXI_ARADDR,
  input  wire  logic        S_AXI_ARVALID,
  output logic              S_AXI_ARREADY,
  output logic [31:0]       S_AXI_RDATA,
  output logic [1:0]        S_AXI_RRESP,
  output logic              S_AXI_RVALID,
  input  wire  logic        S_AXI_RREADY,
  // serial pins
  output logic              TRANSMIT_PIN_O,
  output logic              TRANSMIT_PIN_OE,
  input  wire  logic        RECEIVE_SHARED_PIN_I,
  output logic              RECEIVE_SHARED_PIN_O,
  output logic              RECEIVE_SHARED_PIN_OE,
  // requests
  output logic              IRQ_REQUEST,
  output logic              WAKEUP_REQUEST
);

  function automatic logic [15:0] div_last(input int d);
    div_last = 16'(d - 1);
  endfunction

  // registers
  logic [7:0]  ctl_reg;
  logic        swm_reg;
  logic        gon_reg, clen_reg, clk_off_reg;
  logic [8:0]  txd_reg, rxd_reg;
  logic        tx_empty_reg, tx_idle_reg, rx_avail_reg, overrun_reg, addr_seen_reg, wake_seen_reg;
  logic        aw_reg, w_reg, ws_reg, bv_reg, arv_reg, rv_reg;
  logic [7:0]  awa_reg, ara_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [1:0]  br_reg, rr_reg;
  tx_state_e   tx_st_reg;
  rx_state_e   rx_st_reg;
  logic [15:0] tx_cnt_reg, rx_cnt_reg;
  logic [3:0]  tx_bit_reg, rx_bit_reg;
  logic [9:0]  tx_sh_reg, rx_sh_reg;
  logic        rx_prev_reg, irq_reg, wake_reg;
  logic        tpo_reg, tpoe_reg, spo_reg, spoe_reg;

  // effective enables and pin routing
  wire tx_en   = ctl_reg[BIT_TRANSMITTER_ON] & gon_reg; // R2
  wire rx_en   = ctl_reg[BIT_RECEIVER_ON] & gon_reg; // R5
  wire sw_tx   = swm_reg & tx_en & ~rx_en; // R18 R19
  wire rx_in   = RECEIVE_SHARED_PIN_I;
  wire [3:0] nbits = clen_reg ? 4'h9 : 4'h8; // R21
  wire [3:0] rx_stops = ctl_reg[BIT_RX_STOP_COUNT] ? 4'h2 : 4'h1; // R7
  wire tx_bit_tick = (tx_cnt_reg == div_last(BAUD_DIV));
  wire rx_bit_tick = (rx_cnt_reg == div_last(BAUD_DIV));
  wire rx_half_tick = (rx_cnt_reg == div_last(BAUD_DIV / 2));

  // bus decode
  wire do_write = aw_reg & w_reg & ~bv_reg;
  wire do_read  = arv_reg & ~rv_reg;
  // strobe is taken with the data: the master may have dropped the live strobe by now
  wire wr_ctl   = do_write & (awa_reg == ADDR_TXRX_CONTROL_TWO) & ws_reg;
  wire wr_swm   = do_write & (awa_reg == ADDR_SINGLE_WIRE_CTRL);
  wire wr_glb   = do_write & (awa_reg == ADDR_GLOBAL_CTRL);
  wire wr_sts   = do_write & (awa_reg == ADDR_STATUS);
  wire wr_txd   = do_write & (awa_reg == ADDR_TX_DATA);
  wire wr_clk   = do_write & (awa_reg == ADDR_CLOCK_CTRL);
  wire rd_rxd   = do_read & (ara_reg == ADDR_RX_DATA);
  wire wr_known = wr_ctl | wr_swm | wr_glb | wr_sts | wr_txd | wr_clk | (awa_reg == ADDR_TXRX_CONTROL_TWO);
  wire g_off    = wr_glb & ~wd_reg[BIT_GLOBAL_ON];
  wire [7:0] status_v = {rxd_reg[8], irq_reg, wake_seen_reg, addr_seen_reg,
                         tx_empty_reg, tx_idle_reg, rx_avail_reg, overrun_reg};
  logic [31:0] rdata_v;
  logic        rd_ok;
  always_comb begin
    rdata_v = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ara_reg)
      ADDR_TXRX_CONTROL_TWO: rdata_v = {24'h000000, ctl_reg};
      ADDR_SINGLE_WIRE_CTRL: rdata_v = {31'h0000_0000, swm_reg}; // R20
      ADDR_GLOBAL_CTRL:      rdata_v = {30'h0000_0000, gon_reg, clen_reg};
      ADDR_STATUS:           rdata_v = {24'h000000, status_v};
      ADDR_RX_DATA:          rdata_v = {23'h000000, rxd_reg};
      ADDR_CLOCK_CTRL:       rdata_v = {31'h0000_0000, clk_off_reg};
      default:               rd_ok = 1'b0;
    endcase
  end

  // axi handshake capture
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; bv_reg <= 1'b0; arv_reg <= 1'b0; rv_reg <= 1'b0;
      ws_reg <= 1'b0;
      awa_reg <= 8'h00; ara_reg <= 8'h00; wd_reg <= 32'h0000_0000; rd_reg <= 32'h0000_0000;
      br_reg <= AXI_OKAY; rr_reg <= AXI_OKAY;
    end else begin
      if (S_AXI_AWVALID & ~aw_reg & ~bv_reg) begin
        aw_reg <= 1'b1;
        awa_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID & ~w_reg & ~bv_reg) begin
        w_reg <= 1'b1;
        wd_reg <= S_AXI_WDATA;
        ws_reg <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        bv_reg <= 1'b1;
        br_reg <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end else if (bv_reg & S_AXI_BREADY) begin
        bv_reg <= 1'b0; aw_reg <= 1'b0; w_reg <= 1'b0;
      end
      if (S_AXI_ARVALID & ~arv_reg) begin
        arv_reg <= 1'b1;
        ara_reg <= {S_AXI_ARADDR[7:2], 2'b00};
      end
      if (do_read) begin
        rv_reg <= 1'b1;
        rd_reg <= rdata_v;
        rr_reg <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (rv_reg & S_AXI_RREADY) begin
        rv_reg <= 1'b0; arv_reg <= 1'b0;
      end
    end
  end

  // control registers; global off clears the enables
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctl_reg <= TXRX_CONTROL_TWO_RST; swm_reg <= SINGLE_WIRE_CTRL_RST[0];
      gon_reg <= 1'b0; clen_reg <= 1'b0; clk_off_reg <= 1'b0;
    end else begin
      if (wr_ctl) ctl_reg <= wd_reg[7:0];
      if (wr_swm & ws_reg) swm_reg <= wd_reg[0];
      if (wr_clk) clk_off_reg <= wd_reg[0];
      if (wr_glb) begin
        gon_reg <= wd_reg[BIT_GLOBAL_ON];
        clen_reg <= wd_reg[BIT_CHAR_LENGTH];
      end
      if (g_off) ctl_reg[7:6] <= 2'b00; // R22
    end
  end

  // transmitter: start, data, two stop bits
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || !tx_en) begin // R1 R3
      tx_st_reg <= TX_IDLE; tx_cnt_reg <= 16'h0000; tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF; tx_empty_reg <= 1'b1; tx_idle_reg <= 1'b1; txd_reg <= 9'h000;
    end else begin
      tx_cnt_reg <= (tx_st_reg == TX_IDLE || tx_bit_tick) ? 16'h0000 : tx_cnt_reg + 16'h0001;
      if (wr_txd) begin
        txd_reg <= wd_reg[8:0];
        tx_empty_reg <= 1'b0;
      end
      case (tx_st_reg)
        TX_IDLE: if (!tx_empty_reg) begin
          tx_st_reg <= TX_START; tx_sh_reg <= {1'b1, txd_reg};
          tx_empty_reg <= ~wr_txd; tx_idle_reg <= 1'b0; // a write landing now stays queued
        end
        TX_START: if (tx_bit_tick) begin
          tx_st_reg <= TX_DATA; tx_bit_reg <= 4'h0;
        end
        TX_DATA: if (tx_bit_tick) begin
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_bit_reg <= tx_bit_reg + 4'h1;
          if (tx_bit_reg == nbits - 4'h1) begin
            tx_st_reg <= TX_STOP; tx_bit_reg <= 4'h0;
          end
        end
        TX_STOP: if (tx_bit_tick) begin
          tx_bit_reg <= tx_bit_reg + 4'h1;
          if (tx_bit_reg == 4'(TX_STOP_BITS - 1)) begin // R8
            tx_st_reg <= TX_IDLE; tx_idle_reg <= tx_empty_reg & ~wr_txd;
          end
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // receiver with stop count and address detect
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || !rx_en) begin // R4 R6
      rx_st_reg <= RX_IDLE; rx_cnt_reg <= 16'h0000; rx_bit_reg <= 4'h0; rx_sh_reg <= 10'h000;
    end else begin
      rx_cnt_reg <= (rx_st_reg == RX_IDLE || rx_bit_tick || (rx_st_reg == RX_START && rx_half_tick))
                    ? 16'h0000 : rx_cnt_reg + 16'h0001;
      case (rx_st_reg)
        RX_IDLE: if (rx_prev_reg & ~rx_in & ~sw_tx) rx_st_reg <= RX_START;
        RX_START: if (rx_half_tick) begin
          rx_st_reg <= rx_in ? RX_IDLE : RX_DATA; rx_bit_reg <= 4'h0;
        end
        RX_DATA: if (rx_bit_tick) begin
          rx_sh_reg <= {rx_in, rx_sh_reg[9:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
          if (rx_bit_reg == nbits - 4'h1) begin
            rx_st_reg <= RX_STOP; rx_bit_reg <= 4'h0;
          end
        end
        RX_STOP: if (rx_bit_tick) begin
          rx_bit_reg <= rx_bit_reg + 4'h1;
          if (!rx_in || rx_bit_reg == rx_stops - 4'h1) rx_st_reg <= RX_IDLE; // R7
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end

  // received word completes on last stop bit; address bit is the top data bit
  wire [8:0] rx_word = clen_reg ? rx_sh_reg[9:1] : {1'b0, rx_sh_reg[9:2]};
  wire addr_bit = clen_reg ? rx_word[8] : rx_word[7]; // R9
  wire rx_done = rx_en & (rx_st_reg == RX_STOP) & rx_bit_tick & rx_in & (rx_bit_reg == rx_stops - 4'h1);
  wire keep = ~ctl_reg[BIT_ADDRESS_DETECT] | addr_bit; // R10
  wire st_clr = wr_sts;

  // flags: a hardware set wins over a status-write or data-read clear; global off wins over the set of the overrun, available and address flags
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rxd_reg <= 9'h000; rx_avail_reg <= 1'b0; overrun_reg <= 1'b0; addr_seen_reg <= 1'b0;
      wake_seen_reg <= 1'b0; rx_prev_reg <= 1'b1; wake_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_in;
      if (rd_rxd) rx_avail_reg <= 1'b0;
      if (st_clr & wd_reg[BIT_OVERRUN]) overrun_reg <= 1'b0;
      if (st_clr & wd_reg[BIT_ADDR_SEEN]) addr_seen_reg <= 1'b0;
      if (st_clr & wd_reg[BIT_WAKE_SEEN]) wake_seen_reg <= 1'b0;
      if (rx_done & keep) begin
        rxd_reg <= rx_word;
        rx_avail_reg <= 1'b1;
        if (rx_avail_reg & ~rd_rxd) overrun_reg <= 1'b1;
        if (ctl_reg[BIT_ADDRESS_DETECT]) addr_seen_reg <= 1'b1; // R9
      end
      // wake-up only while the clock is off and enabled
      wake_reg <= 1'b0;
      if (clk_off_reg & ctl_reg[BIT_PIN_WAKEUP] & rx_prev_reg & ~rx_in) begin // R11 R12 R13
        wake_reg <= 1'b1;
        wake_seen_reg <= 1'b1;
      end
      if (g_off) begin // R22
        rx_avail_reg <= 1'b0; overrun_reg <= 1'b0; addr_seen_reg <= 1'b0;
      end
    end
  end

  // interrupt request and pin drivers
  wire irq_v = (ctl_reg[BIT_RX_IRQ] & (overrun_reg | rx_avail_reg | addr_seen_reg)) // R14 R9
             | (ctl_reg[BIT_TX_IDLE_IRQ] & tx_idle_reg) // R15
             | (ctl_reg[BIT_TX_EMPTY_IRQ] & tx_empty_reg) // R16
             | wake_seen_reg; // R23
  wire tx_line = (tx_st_reg == TX_START) ? 1'b0 : (tx_st_reg == TX_DATA) ? tx_sh_reg[0] : 1'b1;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      irq_reg <= 1'b0; tpo_reg <= 1'b1; tpoe_reg <= 1'b0; spo_reg <= 1'b1; spoe_reg <= 1'b0;
    end else begin
      irq_reg <= irq_v;
      tpo_reg <= tx_line;
      tpoe_reg <= tx_en & ~swm_reg; // R17 R1
      spo_reg <= tx_line;
      spoe_reg <= sw_tx; // R18 R19
    end
  end

  assign S_AXI_AWREADY = ~aw_reg & ~bv_reg;
  assign S_AXI_WREADY  = ~w_reg & ~bv_reg;
  assign S_AXI_BVALID  = bv_reg;
  assign S_AXI_BRESP   = br_reg;
  assign S_AXI_ARREADY = ~arv_reg;
  assign S_AXI_RVALID  = rv_reg;
  assign S_AXI_RDATA   = rd_reg;
  assign S_AXI_RRESP   = rr_reg;
  assign TRANSMIT_PIN_O        = tpo_reg;
  assign TRANSMIT_PIN_OE       = tpoe_reg;
  assign RECEIVE_SHARED_PIN_O  = spo_reg;
  assign RECEIVE_SHARED_PIN_OE = spoe_reg;
  assign IRQ_REQUEST    = irq_reg;
  assign WAKEUP_REQUEST = wake_reg;

endmodule

/* File: serial_ctrl_monitor.sv */
// assertion checker bound to the serial control block ports
`timescale 1ns/100ps
module serial_ctrl_monitor
  import serial_ctrl_pkg::*;
(
  // clock, reset and bus
  input wire logic        SYS_CLK, RSTN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
  input wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY,
  input wire logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR,
  input wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP,
  // pins and requests
  input wire logic        TRANSMIT_PIN_O, TRANSMIT_PIN_OE, RECEIVE_SHARED_PIN_I, RECEIVE_SHARED_PIN_O,
  input wire logic        RECEIVE_SHARED_PIN_OE, IRQ_REQUEST, WAKEUP_REQUEST
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // the two pins are never driven at once, whatever the mode
  property p_pin_excl; !(TRANSMIT_PIN_OE && RECEIVE_SHARED_PIN_OE); endproperty
  a_pin_excl: assert property (p_pin_excl) else $error("both pins driven");
  // leaving reset: pins float and no request
  property p_reset_quiet; $rose(RSTN) |-> !IRQ_REQUEST && !TRANSMIT_PIN_OE && !RECEIVE_SHARED_PIN_OE; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_wake_pulse; WAKEUP_REQUEST |=> !WAKEUP_REQUEST; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake request longer than one cycle");
  // bus answers: one write response per request, bounded latency
  property p_b_once; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_b_once: assert property (p_b_once) else $error("write response repeated");
  property p_wr_answer; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response late");
  property p_rd_unmapped; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] > ADDR_CLOCK_CTRL[7:2]
    |-> ##[1:2] (S_AXI_RVALID && S_AXI_RRESP == AXI_SLVERR && S_AXI_RDATA == 32'h00000000); endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  // unused single-wire bits always read zero
  property p_sw_read; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == ADDR_SINGLE_WIRE_CTRL
    |-> ##[1:2] (S_AXI_RVALID && S_AXI_RDATA[31:1] == 31'h00000000); endproperty
  a_sw_read: assert property (p_sw_read) else $error("single-wire upper bits not zero");
endmodule
bind serial_ctrl serial_ctrl_monitor u_mon (.*);

/* File: serial_line_node.sv */
// remote serial node: sends frames on the shared line, captures frames from the transmit pin
`timescale 1ns/100ps
module serial_line_node #(
  parameter int BIT = 4
) (
  // clock and line
  input  wire logic clk,
  input  wire logic tx_pin,
  input  wire logic tx_oe,
  output logic      line_drv
);
  logic [7:0] got;
  logic       stops_ok;
  int         frames, stop_bad;
  // start, n data bits lsb first, s stop bits; released line idles high
  task automatic send(input logic [8:0] w, input int n, input int s);
    @(posedge clk);
    line_drv <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_drv <= w[i];
      repeat (BIT) @(posedge clk);
    end
    line_drv <= 1'b1;
    repeat (BIT * s) @(posedge clk);
  endtask
  // mid-bit capture; both stop bits must read high
  initial begin
    line_drv = 1'b1;
    got = 8'h00;
    stops_ok = 1'b0;
    frames = 0;
    stop_bad = 0;
    forever begin
      do @(posedge clk); while (!(tx_oe === 1'b1 && tx_pin === 1'b0));
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        got[i] = tx_pin;
      end
      repeat (BIT) @(posedge clk);
      stops_ok = tx_pin;
      repeat (BIT) @(posedge clk);
      stops_ok = stops_ok & tx_pin;
      // a short stop shows only when the next start follows at once
      frames++;
      if (stops_ok !== 1'b1) stop_bad++;
    end
  end
endmodule

/* File: serial_ctrl_tb.sv */
// self-checking testbench for the serial control block
`timescale 1ns/100ps
module serial_ctrl_tb;
  import serial_ctrl_pkg::*;
  logic        SYS_CLK, RSTN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, line_drv;
  logic        TRANSMIT_PIN_O, TRANSMIT_PIN_OE, RECEIVE_SHARED_PIN_O, RECEIVE_SHARED_PIN_OE;
  logic        IRQ_REQUEST, WAKEUP_REQUEST;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, v;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [8:0]  d;
  int          seed, wakes, n0, bad_count, checks, cyc;
  // shared line follows the node's drive when released; transmit pin pulled high when released
  wire RECEIVE_SHARED_PIN_I = RECEIVE_SHARED_PIN_OE ? RECEIVE_SHARED_PIN_O : line_drv;
  wire tx_line = TRANSMIT_PIN_OE ? TRANSMIT_PIN_O : 1'b1;
  serial_ctrl #(.BAUD_DIV(4)) dut (.*);
  serial_line_node #(.BIT(4)) node (.clk(SYS_CLK), .tx_pin(tx_line), .tx_oe(TRANSMIT_PIN_OE), .line_drv(line_drv));
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // cycle ceiling and wake pulse count
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (WAKEUP_REQUEST === 1'b1) wakes <= wakes + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge SYS_CLK);
    #10;
  endtask
  // each channel is released at the edge where its ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, dat};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    dat = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {RSTN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h000000000000;
    S_AXI_WSTRB = 4'hF;
    {seed, wakes, bad_count, checks, cyc} = {32'd20, 128'd0};
    repeat (20) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    rd(ADDR_TXRX_CONTROL_TWO, v, r);
    chk(v, {24'h000000, TXRX_CONTROL_TWO_RST});
    rd(8'h1C, v, r);
    chk(r, AXI_SLVERR);
    wr(ADDR_SINGLE_WIRE_CTRL, 8'hFF);
    rd(ADDR_SINGLE_WIRE_CTRL, v, r);
    chk(v, 32'h00000001);
    wr(ADDR_SINGLE_WIRE_CTRL, 8'h00);
    wr(ADDR_GLOBAL_CTRL, 8'h02);
    wr(ADDR_TXRX_CONTROL_TWO, 8'h80);
    wt(3);
    chk({TRANSMIT_PIN_OE, RECEIVE_SHARED_PIN_OE}, 2'b10);
    // two random characters back to back, then each tx flag alone raises the request
    d = 9'($random(seed));
    wr(ADDR_TX_DATA, d[7:0]);
    d = 9'($random(seed));
    wr(ADDR_TX_DATA, d[7:0]);
    wt(110);
    chk({node.stops_ok, node.got}, {1'b1, d[7:0]});
    chk(node.stop_bad, 0);
    chk(node.frames, 2);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_TXRX_CONTROL_TWO, 8'h80 | (8'h01 << i));
      wt(3);
      chk(IRQ_REQUEST, i < 2);
    end
    // one stop bit sent: a two-stop receiver finishes one bit time later
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TXRX_CONTROL_TWO, s ? 8'h64 : 8'h44);
      d = 9'($random(seed));
      node.send(d, 8, 1);
      wt(1);
      chk(IRQ_REQUEST, s == 0);
      wt(4);
      chk(IRQ_REQUEST, 1'b1);
      rd(ADDR_RX_DATA, v, r);
      chk(v[7:0], d[7:0]);
      wt(3);
      chk(IRQ_REQUEST, 1'b0);
    end
    // address detect: data word dropped, address word kept
    wr(ADDR_TXRX_CONTROL_TWO, 8'h54);
    node.send({2'b00, d[6:0]}, 8, 1);
    wt(4);
    rd(ADDR_STATUS, v, r);
    chk({IRQ_REQUEST, v[BIT_RX_AVAIL]}, 2'b00);
    node.send({2'b01, d[6:0]}, 8, 1);
    wt(4);
    rd(ADDR_STATUS, v, r);
    chk({IRQ_REQUEST, v[BIT_ADDR_SEEN]}, 2'b11);
    rd(ADDR_RX_DATA, v, r);
    wr(ADDR_STATUS, 8'h10);
    // receiver switched off mid-character must drop it
    wr(ADDR_TXRX_CONTROL_TWO, 8'h44);
    fork
      node.send(9'h0FF, 8, 1);
    join_none
    wt(12);
    wr(ADDR_TXRX_CONTROL_TWO, 8'h04);
    wr(ADDR_TXRX_CONTROL_TWO, 8'h44);
    wt(40);
    chk(IRQ_REQUEST, 1'b0);
    // transmitter switched off mid-character floats and resets
    wr(ADDR_TXRX_CONTROL_TWO, 8'h80);
    wr(ADDR_TX_DATA, 8'h00);
    wt(12);
    wr(ADDR_TXRX_CONTROL_TWO, 8'h00);
    wt(2);
    chk(TRANSMIT_PIN_OE, 1'b0);
    wr(ADDR_TXRX_CONTROL_TWO, 8'h80);
    wt(3);
    chk(TRANSMIT_PIN_O, 1'b1);
    wr(ADDR_SINGLE_WIRE_CTRL, 8'h01);
    wt(3);
    chk({TRANSMIT_PIN_OE, RECEIVE_SHARED_PIN_OE}, 2'b01);
    wr(ADDR_TXRX_CONTROL_TWO, 8'hC0);
    wt(3);
    chk(RECEIVE_SHARED_PIN_OE, 1'b0);
    wr(ADDR_SINGLE_WIRE_CTRL, 8'h00);
    // wake: clock off and on, wake-up bit set and clear
    wr(ADDR_CLOCK_CTRL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_TXRX_CONTROL_TWO, k == 1 ? 8'h00 : 8'h08);
      if (k == 2) wr(ADDR_CLOCK_CTRL, 8'h00);
      n0 = wakes;
      node.send(9'h000, 0, 1);
      wt(4);
      chk(wakes - n0, k == 0);
    end
    wr(ADDR_TXRX_CONTROL_TWO, 8'hC0);
    wr(ADDR_GLOBAL_CTRL, 8'h00);
    rd(ADDR_TXRX_CONTROL_TWO, v, r);
    chk(v[7:6], 2'b00);
    tally_and_finish;
  end
endmodule
